// ===== rtl/ddc_pkg.sv
package ddc_pkg;

  // frame layout, msb first
  localparam int          FRAME_BITS  = 16;
  localparam int          F_CMD_HI    = 15;
  localparam int          F_CMD_LO    = 14;
  localparam int          F_ADR_HI    = 13;
  localparam int          F_ADR_LO    = 8;
  localparam int          F_DAT_HI    = 7;
  localparam int          F_DAT_LO    = 0;
  localparam int          LOCK_HI     = 7;
  localparam int          LOCK_LO     = 5;

  localparam logic [1:0]  CMD_WRITE   = 2'h2;
  localparam logic [1:0]  CMD_READ    = 2'h1;
  localparam logic [1:0]  RESP_READ   = 2'h1;

  // {primary_address_field, secondary_address_field}
  localparam logic [5:0]  ADR_OUT     = 6'h00;
  localparam logic [5:0]  ADR_MAP0    = 6'h04;
  localparam logic [5:0]  ADR_MAP1    = 6'h05;
  localparam logic [5:0]  ADR_STAT    = 6'h06;
  localparam logic [5:0]  ADR_OLC     = 6'h08;
  localparam logic [5:0]  ADR_LOCK    = 6'h28;

  localparam logic [7:0]  RST_OUT     = 8'h00;
  localparam logic [7:0]  RST_MAP0    = 8'h04;
  localparam logic [7:0]  RST_MAP1    = 8'h08;
  localparam logic [7:0]  RST_OLC     = 8'h00;

  localparam logic [2:0]  LOCK_ON     = 3'h6;
  localparam logic [2:0]  LOCK_OFF    = 3'h3;

  // clock counter of a frame, saturates at a value that is no byte multiple
  localparam int          CNT_W       = 10;
  localparam int          BYTE_BITS   = 3;
  localparam logic [9:0]  CNT_MIN     = 10'h010;
  localparam logic [9:0]  CNT_MAX     = 10'h3ff;
  localparam int          SYNC_W      = 5;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } ddc_state_t;

  typedef enum logic {
    RS_DIAG = 1'b0,
    RS_REG  = 1'b1
  } ddc_resp_t;

endpackage

// ===== rtl/ddc_sync.sv
`timescale 1ns/100ps
module ddc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ddc_sync_s_t;

  ddc_sync_s_t s_q;
  ddc_sync_s_t s_d;

  // meta feeds only the second stage
  always_comb begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.sync;

endmodule

// ===== rtl/ddc_regs.sv
`timescale 1ns/100ps
// Summary of operation
// R1 - undervoltage bit 14 sticks until diagnosis word read out, one after reset
// R2 - bits 12-11 report mode: 01 limp home, 10 active, 11 idle
// R3 - transfer error bit 10 clears only after 16 plus multiple of 8 clocks
// R4 - first frame after reset sends input status with transfer error set
// R5 - second frame after reset is diagnosis word, error cleared if transfer good
// R6 - bit 8 flags off channel with test current whose drain is below threshold
// R7 - bits 7-0 carry per channel overload or overtemperature fault flags
// R8 - output enable bits switch channels on, reset all off
// R9 - input-0 map links channels to pin 0, reset links channel 2
// R10 - input-1 map links channels to pin 1, reset links channel 3
// R11 - input status register is the first content sent after reset
// R12 - status bit 7 mirrors transfer error, bits 6-2 reserved read zero
// R13 - status bits 1 and 0 show the levels of pins 1 and 0
// R14 - open-load register enables per channel test current, all off at reset
// R15 - write frame starts 10 with addresses and data, read frame starts 01
// R16 - reads of reserved or unused addresses answer with the diagnosis word
// R17 - lock code 110 blocks register writes, only 011 unlocks again
// R18 - channel on when its enable set or mapped to a high pin
module ddc_regs (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sdi,
  input  wire logic       in0_pin,
  input  wire logic       in1_pin,
  input  wire logic [7:0] channel_fault_flag,
  input  wire logic [7:0] drain_below_threshold,
  input  wire logic       supply_undervolt_event,
  input  wire logic [1:0] op_mode,
  output logic            spi_sdo,
  output logic            spi_sdo_oe,
  output logic      [7:0] channel_on,
  output logic      [7:0] test_current_enable
);

  typedef struct packed {
    ddc_pkg::ddc_state_t st;
    logic [15:0]         sh;
    logic [9:0]          cnt;
    logic                rose_seen;
    logic                cs_p;
    logic                sclk_p;
    logic                sdo;
    logic                sdo_oe;
    logic [7:0]          oe;
    logic [7:0]          map0;
    logic [7:0]          map1;
    logic [7:0]          olc;
    logic [7:0]          on;
    logic                uv;
    logic                transfer_error_flag;
    logic                first;
    logic                locked;
    ddc_pkg::ddc_resp_t  rsel;
    logic [5:0]          raddr;
  } ddc_regs_s_t;

  ddc_regs_s_t q;
  ddc_regs_s_t n;

  logic [4:0]  pins_s;
  logic        cs_s;
  logic        sclk_s;
  logic        sdi_s;
  logic        in0_s;
  logic        in1_s;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        load;
  logic        frame_end;
  logic        valid;
  logic        open_load_off_flag;
  logic [1:0]  cmd;
  logic [5:0]  adr;
  logic [7:0]  dat;
  logic        known_rd;
  logic [7:0]  stat8;
  logic [7:0]  reg_val;
  logic [15:0] diag;

  // cs passes inverted so the sync flops reset to its idle level, no false fall
  // sdi rides the same sync delay as sclk, so the falling edge sees settled data
  ddc_sync #(
    .WIDTH (ddc_pkg::SYNC_W)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({~spi_cs_n, spi_sclk, spi_sdi, in1_pin, in0_pin}),
    .q    (pins_s)
  );

  assign cs_s      = ~pins_s[4];
  assign sclk_s    = pins_s[3];
  assign sdi_s     = pins_s[2];
  assign in1_s     = pins_s[1];
  assign in0_s     = pins_s[0];
  assign cs_fall   = q.cs_p & ~cs_s;
  assign cs_rise   = ~q.cs_p & cs_s;
  assign sclk_rise = ~q.sclk_p & sclk_s;
  assign sclk_fall = q.sclk_p & ~sclk_s;
  assign load      = (q.st == ddc_pkg::ST_IDLE) & cs_fall;
  assign frame_end = (q.st == ddc_pkg::ST_SHIFT) & cs_rise;

  // daisy chains pass 16 plus whole bytes
  assign valid = (q.cnt >= ddc_pkg::CNT_MIN) & (q.cnt[ddc_pkg::BYTE_BITS-1:0] == '0); // R3
  assign cmd   = q.sh[ddc_pkg::F_CMD_HI:ddc_pkg::F_CMD_LO];
  assign adr   = q.sh[ddc_pkg::F_ADR_HI:ddc_pkg::F_ADR_LO];
  assign dat   = q.sh[ddc_pkg::F_DAT_HI:ddc_pkg::F_DAT_LO];
  assign known_rd = adr inside {ddc_pkg::ADR_OUT, ddc_pkg::ADR_MAP0, ddc_pkg::ADR_MAP1,
                                ddc_pkg::ADR_STAT, ddc_pkg::ADR_OLC};

  // channels that are on never count as open load
  assign open_load_off_flag = |(~q.on & q.olc & drain_below_threshold); // R6
  assign stat8 = {q.transfer_error_flag, 5'h00, in1_s, in0_s}; // R12 R13
  assign diag  = {1'b0, q.uv, 1'b0, op_mode, q.transfer_error_flag, 1'b0, open_load_off_flag, channel_fault_flag}; // R1 R2 R3 R6 R7

  always_comb begin
    case (q.raddr)
      ddc_pkg::ADR_OUT:  reg_val = q.oe;
      ddc_pkg::ADR_MAP0: reg_val = q.map0;
      ddc_pkg::ADR_MAP1: reg_val = q.map1;
      ddc_pkg::ADR_STAT: reg_val = stat8;
      ddc_pkg::ADR_OLC:  reg_val = q.olc;
      default:           reg_val = 8'h00;
    endcase
  end

  always_comb begin
    n        = q;
    n.cs_p   = cs_s;
    n.sclk_p = sclk_s;
    n.sdo_oe = ~cs_s;
    n.on     = q.oe | (q.map0 & {8{in0_s}}) | (q.map1 & {8{in1_s}}); // R8 R9 R10 R18
    case (q.st)
      ddc_pkg::ST_IDLE: begin
        if (cs_fall) begin
          n.st        = ddc_pkg::ST_SHIFT;
          n.cnt       = '0;
          n.rose_seen = 1'b0;
          n.sdo       = q.transfer_error_flag | sdi_s;
          if (q.rsel == ddc_pkg::RS_DIAG) begin
            n.sh = diag;
            n.uv = 1'b0; // R1
          end else begin
            n.sh = {ddc_pkg::RESP_READ, q.raddr, reg_val}; // R4 R11
          end
        end
      end
      ddc_pkg::ST_SHIFT: begin
        // before the first rising edge the line shows error or upstream data
        if (!q.rose_seen) begin
          n.sdo = q.transfer_error_flag | sdi_s;
        end
        if (sclk_rise) begin
          n.sdo       = q.sh[ddc_pkg::F_CMD_HI];
          n.rose_seen = 1'b1;
        end
        if (sclk_fall) begin
          n.sh = {q.sh[ddc_pkg::F_CMD_HI-1:0], sdi_s};
          if (q.cnt != ddc_pkg::CNT_MAX) begin
            n.cnt = q.cnt + 10'h001;
          end
        end
        if (cs_rise) begin
          n.st    = ddc_pkg::ST_IDLE;
          n.transfer_error_flag   = ~valid; // R3 R5
          n.first = 1'b0;
          n.rsel  = ddc_pkg::RS_DIAG; // R5
          if (valid && cmd == ddc_pkg::CMD_WRITE) begin // R15
            if (adr == ddc_pkg::ADR_LOCK) begin
              if (!q.locked && dat[ddc_pkg::LOCK_HI:ddc_pkg::LOCK_LO] == ddc_pkg::LOCK_ON) begin
                n.locked = 1'b1; // R17
              end else if (q.locked && dat[ddc_pkg::LOCK_HI:ddc_pkg::LOCK_LO] == ddc_pkg::LOCK_OFF) begin
                n.locked = 1'b0; // R17
              end
            end else if (!q.locked) begin // R17
              case (adr)
                ddc_pkg::ADR_OUT:  n.oe   = dat; // R8
                ddc_pkg::ADR_MAP0: n.map0 = dat; // R9
                ddc_pkg::ADR_MAP1: n.map1 = dat; // R10
                ddc_pkg::ADR_OLC:  n.olc  = dat; // R14
                default: ;
              endcase
            end
          end
          // unknown addresses keep the diagnosis answer
          if (valid && cmd == ddc_pkg::CMD_READ && known_rd && !q.first) begin // R15 R16
            n.rsel  = ddc_pkg::RS_REG;
            n.raddr = adr;
          end
        end
      end
      default: n.st = ddc_pkg::ST_IDLE;
    endcase
    // a new event beats the readout clear
    if (supply_undervolt_event) begin
      n.uv = 1'b1; // R1
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q       <= '0;
      q.cs_p  <= 1'b1;
      q.oe    <= ddc_pkg::RST_OUT; // R8
      q.map0  <= ddc_pkg::RST_MAP0; // R9
      q.map1  <= ddc_pkg::RST_MAP1; // R10
      q.olc   <= ddc_pkg::RST_OLC; // R14
      q.uv    <= 1'b1; // R1
      q.transfer_error_flag   <= 1'b1; // R4
      q.first <= 1'b1;
      q.rsel  <= ddc_pkg::RS_REG; // R11
      q.raddr <= ddc_pkg::ADR_STAT; // R11
    end else begin
      q <= n;
    end
  end

  assign spi_sdo             = q.sdo;
  assign spi_sdo_oe          = q.sdo_oe;
  assign channel_on          = q.on;
  assign test_current_enable = q.olc;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_uv_sticky: assert property (supply_undervolt_event |=> q.uv) // R1
    else $error("undervoltage event not latched");
  a_uv_readout: assert property (load && q.rsel == ddc_pkg::RS_DIAG && !supply_undervolt_event |=> !q.uv) // R1
    else $error("undervoltage flag not cleared by readout");
  a_diag_load: assert property (load && q.rsel == ddc_pkg::RS_DIAG |=> q.sh == $past(diag)) // R2
    else $error("diagnosis word not loaded");
  a_ter_fail: assert property (frame_end && !valid |=> q.transfer_error_flag ##1 q.rsel == ddc_pkg::RS_DIAG) // R3
    else $error("bad frame did not set transfer error");
  a_ter_pass: assert property (frame_end && valid |=> !q.transfer_error_flag) // R5
    else $error("good frame left transfer error set");
  a_first_status: assert property (load && q.first |=> // R4
      q.sh[ddc_pkg::F_ADR_HI:ddc_pkg::F_ADR_LO] == ddc_pkg::ADR_STAT && q.sh[ddc_pkg::F_DAT_HI])
    else $error("first answer not input status with error set");
  a_second_diag: assert property (frame_end && q.first |=> q.rsel == ddc_pkg::RS_DIAG) // R5
    else $error("second answer not diagnosis");
  a_unmapped_read: assert property (frame_end && valid && cmd == ddc_pkg::CMD_READ && !known_rd // R16
      |=> q.rsel == ddc_pkg::RS_DIAG)
    else $error("unmapped read not answered by diagnosis");
  a_lock_hold: assert property (frame_end && q.locked && adr != ddc_pkg::ADR_LOCK // R17
      |=> $stable(q.oe) && $stable(q.map0) && $stable(q.map1) && $stable(q.olc))
    else $error("write taken while locked");
  a_write_out: assert property (frame_end && valid && cmd == ddc_pkg::CMD_WRITE && adr == ddc_pkg::ADR_OUT // R15
      && !q.locked |=> q.oe == $past(dat))
    else $error("output enable write lost");
  a_olc_write: assert property (frame_end && valid && cmd == ddc_pkg::CMD_WRITE && adr == ddc_pkg::ADR_OLC // R14
      && !q.locked |=> test_current_enable == $past(dat))
    else $error("test current write lost");
  a_channel_drive: assert property (q.oe != 8'h00 |=> (channel_on & $past(q.oe)) == $past(q.oe)) // R18
    else $error("enabled channel not on");
  a_pin0_map: assert property (in0_s && q.map0 != 8'h00 |=> (channel_on & $past(q.map0)) == $past(q.map0)) // R9
    else $error("pin 0 mapped channel not on");
  a_pin1_map: assert property (in1_s && q.map1 != 8'h00 |=> (channel_on & $past(q.map1)) == $past(q.map1)) // R10
    else $error("pin 1 mapped channel not on");

  a_map0_write: assert property (frame_end && valid && cmd == ddc_pkg::CMD_WRITE && adr == ddc_pkg::ADR_MAP0 // R9
      && !q.locked |=> q.map0 == $past(dat))
    else $error("input 0 map write lost");
  a_map1_write: assert property (frame_end && valid && cmd == ddc_pkg::CMD_WRITE && adr == ddc_pkg::ADR_MAP1 // R10
      && !q.locked |=> q.map1 == $past(dat))
    else $error("input 1 map write lost");
  a_status_error: assert property (load && q.rsel == ddc_pkg::RS_REG && q.raddr == ddc_pkg::ADR_STAT // R12
      |=> q.sh[ddc_pkg::F_DAT_HI] == $past(q.transfer_error_flag))
    else $error("status error bit does not follow transfer error");
  a_status_pins: assert property (load && q.rsel == ddc_pkg::RS_REG && q.raddr == ddc_pkg::ADR_STAT // R13
      |=> q.sh[ddc_pkg::F_DAT_LO+1:ddc_pkg::F_DAT_LO] == $past({in1_s, in0_s}))
    else $error("status pin levels wrong");
  a_openload_masked: assert property (load && q.rsel == ddc_pkg::RS_DIAG && &(q.on | ~q.olc) // R6
      |=> !q.sh[ddc_pkg::F_ADR_LO])
    else $error("open load flagged with no off channel under test");
  a_fault_field: assert property (load && q.rsel == ddc_pkg::RS_DIAG // R7
      |=> q.sh[ddc_pkg::F_DAT_HI:ddc_pkg::F_DAT_LO] == $past(channel_fault_flag))
    else $error("fault flags not in diagnosis word");
  a_lock_set: assert property (frame_end && valid && cmd == ddc_pkg::CMD_WRITE && adr == ddc_pkg::ADR_LOCK // R17
      && dat[ddc_pkg::LOCK_HI:ddc_pkg::LOCK_LO] == ddc_pkg::LOCK_ON |=> q.locked)
    else $error("lock code not taken");
  a_lock_clear: assert property (frame_end && valid && cmd == ddc_pkg::CMD_WRITE && adr == ddc_pkg::ADR_LOCK // R17
      && dat[ddc_pkg::LOCK_HI:ddc_pkg::LOCK_LO] == ddc_pkg::LOCK_OFF |=> !q.locked)
    else $error("unlock code not taken");
  a_read_capture: assert property (frame_end && valid && cmd == ddc_pkg::CMD_READ && known_rd && !q.first // R15
      |=> q.rsel == ddc_pkg::RS_REG && q.raddr == $past(adr))
    else $error("read address not captured");
  a_sdo_early: assert property (load |=> spi_sdo == $past(q.transfer_error_flag | sdi_s)) // R3
    else $error("early output not error or upstream data");
  a_channel_off: assert property (q.oe == 8'h00 && !(in0_s && q.map0 != 8'h00) && !(in1_s && q.map1 != 8'h00) // R8
      |=> channel_on == 8'h00)
    else $error("channel on with nothing driving it");

  c_write: cover property (frame_end && valid && cmd == ddc_pkg::CMD_WRITE);
  c_read: cover property (frame_end && valid && cmd == ddc_pkg::CMD_READ && known_rd);
  c_bad_frame: cover property (frame_end && !valid);
  c_locked: cover property (q.locked ##1 frame_end);
  c_first_frame: cover property (load && q.first);

endmodule

// ===== sim/ddc_host.sv
`timescale 1ns/100ps
module ddc_host (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // sclk rests low at both cs edges; a floating sdo reads unknown
  task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] ans, output logic pre);
    ans = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    sdi  <= w[n-1];
    repeat (10) @(posedge clk);
    pre = sdo_oe ? sdo : 1'bx;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      sdi  <= w[i];
      sclk <= 1'b1;
      repeat (20) @(posedge clk);
      if (n - 1 - i < 16) ans[i - n + 16] = sdo_oe ? sdo : 1'bx;
      sclk <= 1'b0;
      repeat (19) @(posedge clk);
    end
    @(posedge clk);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    repeat (12) @(posedge clk);
  endtask
endmodule

// ===== sim/ddc_regs_test.sv
`timescale 1ns/100ps
module ddc_regs_test;
  logic        clk, srst, cs_n, sclk, sdi, in0_pin, in1_pin, uv_ev, sdo, sdo_oe;
  logic [7:0]  fault, drain, chan_on, tce, oe, m0, m1, olc;
  logic [1:0]  op_mode, nxt;
  logic        transfer_error_flag, uv, first, lck;
  logic [5:0]  nadr;
  logic [31:0] seed, r;
  logic [5:0]  adrs [8] = '{6'h00, 6'h04, 6'h05, 6'h06, 6'h08, 6'h10, 6'h15, 6'h3f};
  int          error_cnt, n_tests;

  ddc_regs dut (.clk(clk), .srst(srst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .in0_pin(in0_pin),
    .in1_pin(in1_pin), .channel_fault_flag(fault), .drain_below_threshold(drain), .supply_undervolt_event(uv_ev),
    .op_mode(op_mode), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .channel_on(chan_on), .test_current_enable(tce));
  ddc_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic frame(input logic [15:0] c, input int n);
    logic [31:0] w;
    logic [15:0] ans, ex, st, dg;
    logic [7:0]  ch, rv;
    logic [5:0]  a;
    logic        pre, ok;
    w = {16'hc3a5, c};
    repeat (10) @(posedge clk);
    ch = oe | (in0_pin ? m0 : 8'h00) | (in1_pin ? m1 : 8'h00);
    st = {2'h1, 6'h06, transfer_error_flag, 5'h00, in1_pin, in0_pin};
    dg = {1'b0, uv, 1'b0, op_mode, transfer_error_flag, 1'b0, |(~ch & olc & drain), fault};
    case (nadr)
      6'h00: rv = oe;
      6'h04: rv = m0;
      6'h05: rv = m1;
      6'h06: rv = st[7:0];
      default: rv = olc;
    endcase
    ex = (nxt == 2'h2) ? st : (nxt == 2'h1) ? {2'h1, nadr, rv} : dg;
    if (nxt == 2'h0) uv = 1'b0;
    host.xfer(w, n, ans, pre);
    chk(pre, transfer_error_flag | w[n-1], "sdo_pre");
    if (n >= 16) chk(ans, ex, "answer");
    ok  = (n >= 16) && ((n - 16) % 8 == 0);
    transfer_error_flag = !ok;
    nxt = 2'h0;
    a   = c[13:8];
    if (ok && c[15:14] == 2'h1 && !first && (a inside {6'h00, 6'h04, 6'h05, 6'h06, 6'h08})) begin
      nxt  = 2'h1;
      nadr = a;
    end
    if (ok && c[15:14] == 2'h2 && (!lck || a == 6'h28)) begin
      case (a)
        6'h00: oe = c[7:0];
        6'h04: m0 = c[7:0];
        6'h05: m1 = c[7:0];
        6'h08: olc = c[7:0];
        6'h28: lck = (c[7:5] == 3'h6) ? 1'b1 : (c[7:5] == 3'h3) ? 1'b0 : lck;
        default: ;
      endcase
    end
    first = 1'b0;
    ch = oe | (in0_pin ? m0 : 8'h00) | (in1_pin ? m1 : 8'h00);
    chk(chan_on, ch, "channel_on");
    chk(tce, olc, "test_current");
  endtask

  initial begin
    seed = 32'h72629649;
    {srst, in0_pin, in1_pin, uv_ev, op_mode, fault, drain} = {4'h8, 2'h3, 16'h0000};
    {oe, m0, m1, olc, transfer_error_flag, uv, first, lck, nxt, nadr} = {32'h00040800, 4'he, 2'h2, 6'h00};
    error_cnt = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    frame(16'h4000, 16);
    frame(16'h4400, 16);
    frame(16'h4500, 16);
    frame(16'h4600, 16);
    frame(16'h4800, 16);
    frame(16'h8481, 16);
    frame(16'h8542, 16);
    frame(16'h88f0, 16);
    frame(16'h4400, 16);
    frame(16'ha8c0, 16);
    frame(16'h80ff, 16);
    frame(16'h4000, 16);
    frame(16'ha860, 16);
    frame(16'h805a, 16);
    frame(16'h4000, 16);
    // random traffic, a quarter of frames with a bad clock count
    for (int k = 0; k < 70; k++) begin
      r = $random(seed);
      @(posedge clk);
      {in1_pin, in0_pin, op_mode, uv_ev, fault, drain} <= {r[4:0], r[23:8]};
      if (r[0]) uv = 1'b1;
      @(posedge clk);
      uv_ev <= 1'b0;
      frame({r[29:28], r[24] ? 6'h28 : adrs[r[27:25]],
        r[7:0] ^ r[31:24]}, r[31] ? 16 : r[30] ? 24 : r[5] ? 15 : 20);
    end
    complete_run();
  end

  initial begin
    #360000;
    error_cnt++;
    complete_run();
  end
endmodule
